/* dle_timebase.sv */
// Constants for the detector level evaluator, and its seconds/day time base.
// Assumes one free-running clock and the asynchronous active-low reset.
`timescale 1ns/1ns

package dle_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int DET_COUNT = 16;
    localparam int ADDR_W    = 4;
    localparam int PW_W      = 12;
    localparam int AVG_W     = 16;
    localparam int AVG_SHIFT = 4;
    localparam int SENS_W    = 4;
    localparam int IDX_W     = 4;
    localparam int LVL_COUNT = 16;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int SECOND_NS       = 1000000000;
    localparam int CYCLES_PER_SEC  = SECOND_NS / CLOCK_PERIOD_NS;
    localparam int DAY_HOURS       = 24;
    localparam int SECONDS_PER_DAY = DAY_HOURS * 3600;
    localparam int SETTLE_S        = 60;
    localparam int SETTLE_W        = 6;
    localparam logic [SETTLE_W-1:0] SETTLE_COUNT = SETTLE_S[SETTLE_W-1:0];

    // ****************************************
    // Thresholds
    // ****************************************
    localparam int PRE_PERCENT  = 67;
    localparam int LOW_PERCENT  = 10;
    localparam int PERCENT_BASE = 100;

    localparam logic [PW_W-1:0] MAINT_SENS_P1 = 12'h490;
    localparam logic [PW_W-1:0] MAINT_SENS_0  = 12'h530;
    localparam logic [PW_W-1:0] MAINT_SENS_M1 = 12'h590;
    localparam logic [PW_W-1:0] MAINT_SENS_M2 = 12'h620;

    localparam logic [PW_W-1:0] PHOTO_NORMAL_LOW = 12'h210;
    localparam logic [PW_W-1:0] HEAT_NORMAL_LOW  = 12'h340;
    localparam logic [PW_W-1:0] PTIR_NORMAL_LOW  = 12'h2F8;
    localparam logic [PW_W-1:0] HPHO_NORMAL_LOW  = 12'h360;

    localparam logic [PW_W-1:0] PTIR_MAINT_LO = 12'h0F0;
    localparam logic [PW_W-1:0] PTIR_MAINT_HI = 12'h160;
    localparam logic [PW_W-1:0] HPHO_MAINT_LO = 12'h0F0;
    localparam logic [PW_W-1:0] HPHO_MAINT_HI = 12'h2B0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [PW_W-1:0]   ALARM_RESET = 12'hFFF;
    localparam logic [PW_W-1:0]   LEVEL_RESET = 12'hFFF;
    localparam logic [SENS_W-1:0] SENS_RESET  = 4'h0;
    localparam logic [IDX_W-1:0]  IDX_RESET   = 4'h1;

    typedef enum logic [2:0] {
        DET_PHOTO,
        DET_ION,
        DET_BEAM,
        DET_HEAT,
        DET_PTIR,
        DET_HPHO
    } dle_det_type_t;

endpackage

module dle_timebase #(
    parameter int CYCLES_PER_SEC  = dle_pkg::CYCLES_PER_SEC,
    parameter int SECONDS_PER_DAY = dle_pkg::SECONDS_PER_DAY
) (
    input  wire logic clock,
    input  wire logic reset_n,
    output logic      sec_tick,
    output logic      day_tick
);

    logic [31:0] cyc_reg;
    logic [31:0] sec_reg;
    logic        wrap_cyc;
    logic        wrap_sec;

    assign wrap_cyc = (cyc_reg == 32'(CYCLES_PER_SEC - 1));
    assign wrap_sec = (sec_reg == 32'(SECONDS_PER_DAY - 1));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cyc_reg  <= 32'h0;
            sec_reg  <= 32'h0;
            sec_tick <= 1'b0;
            day_tick <= 1'b0;
        end else begin
            cyc_reg  <= wrap_cyc ? 32'h0 : cyc_reg + 32'h1;
            sec_tick <= wrap_cyc;
            day_tick <= wrap_cyc && wrap_sec;
            if (wrap_cyc) begin
                sec_reg <= wrap_sec ? 32'h0 : sec_reg + 32'h1;
            end
        end
    end

endmodule

/* dle_evaluator.sv */
// Per-detector level evaluation: alarm, pre-alarm, maintenance, low trouble.
// Assumes samples and configuration arrive as one-cycle strobes on this clock.

`timescale 1ns/1ns

module dle_evaluator #(
    parameter int CYCLES_PER_SEC  = dle_pkg::CYCLES_PER_SEC,
    parameter int SECONDS_PER_DAY = dle_pkg::SECONDS_PER_DAY
) (
    input  wire logic                          clock,
    input  wire logic                          reset_n,
    input  wire logic                          sample_valid,
    input  wire logic [dle_pkg::ADDR_W-1:0]    sample_addr,
    input  wire logic [dle_pkg::PW_W-1:0]      analog_pulse_width_value,
    input  wire logic                          missing_valid,
    input  wire logic [dle_pkg::ADDR_W-1:0]    missing_addr,
    input  wire logic                          cfg_valid,
    input  wire logic [dle_pkg::ADDR_W-1:0]    cfg_addr,
    input  wire dle_pkg::dle_det_type_t        cfg_type,
    input  wire logic [dle_pkg::PW_W-1:0]      cfg_alarm_threshold_level,
    input  wire logic [dle_pkg::IDX_W-1:0]     cfg_level_index,
    input  wire logic signed [dle_pkg::SENS_W-1:0] cfg_sensitivity,
    input  wire logic                          lvl_valid,
    input  wire logic [dle_pkg::IDX_W-1:0]     lvl_index,
    input  wire logic [dle_pkg::PW_W-1:0]      lvl_value,
    output logic                               result_valid,
    output logic [dle_pkg::ADDR_W-1:0]         result_addr,
    output logic [dle_pkg::PW_W-1:0]           result_value,
    output logic [dle_pkg::PW_W-1:0]           result_clean_air_baseline,
    output logic                               result_alarm,
    output logic                               result_prealarm,
    output logic                               result_maint,
    output logic                               result_low
);

    localparam int N = dle_pkg::DET_COUNT;
    localparam int W = dle_pkg::PW_W;
    localparam int AW = dle_pkg::ADDR_W;

    // ****************************************
    // Storage
    // ****************************************
    dle_pkg::dle_det_type_t              type_reg      [N];
    logic [W-1:0]                        alarm_thr_reg [N];
    logic [dle_pkg::IDX_W-1:0]           idx_reg       [N];
    logic signed [dle_pkg::SENS_W-1:0]   sens_reg      [N];
    logic [W-1:0]                        baseline_reg  [N];
    logic [dle_pkg::AVG_W-1:0]           avg_reg       [N];
    logic [dle_pkg::SETTLE_W-1:0]        settle_reg    [N];
    logic                                present_reg   [N];
    logic                                loaded_reg    [N];
    logic [W-1:0]                        level_reg     [dle_pkg::LVL_COUNT];

    logic sec_tick;
    logic day_tick;

    dle_timebase #(
        .CYCLES_PER_SEC  (CYCLES_PER_SEC),
        .SECONDS_PER_DAY (SECONDS_PER_DAY)
    ) u_timebase (
        .clock    (clock),
        .reset_n  (reset_n),
        .sec_tick (sec_tick),
        .day_tick (day_tick)
    );

    // ****************************************
    // Per-detector state
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_det
            logic hit_sample;
            logic hit_cfg;
            logic hit_missing;
            logic do_load;
            logic smoke;
            logic [dle_pkg::AVG_W-1:0] avg_next;

            assign hit_sample  = sample_valid && (sample_addr == AW'(gi));
            assign hit_cfg     = cfg_valid && (cfg_addr == AW'(gi));
            assign hit_missing = missing_valid && (missing_addr == AW'(gi));
            assign do_load     = hit_sample && !loaded_reg[gi]
                                 && (settle_reg[gi] == dle_pkg::SETTLE_COUNT);
            assign smoke       = (type_reg[gi] != dle_pkg::DET_HEAT);
            // Leaky sum: sixteen times the running mean, so a spike moves it little
            assign avg_next    = avg_reg[gi] - (avg_reg[gi] >> dle_pkg::AVG_SHIFT)
                                 + {4'h0, analog_pulse_width_value};

            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    type_reg[gi]      <= dle_pkg::DET_PHOTO;
                    alarm_thr_reg[gi] <= dle_pkg::ALARM_RESET;
                    idx_reg[gi]       <= dle_pkg::IDX_RESET;
                    sens_reg[gi]      <= dle_pkg::SENS_RESET;
                end else if (hit_cfg) begin
                    type_reg[gi]      <= cfg_type;
                    alarm_thr_reg[gi] <= cfg_alarm_threshold_level;
                    idx_reg[gi]       <= cfg_level_index;
                    sens_reg[gi]      <= cfg_sensitivity;
                end
            end

            // Missing wins: a sample in the same cycle does not restart power-up
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    present_reg[gi] <= 1'b1;
                    settle_reg[gi]  <= '0;
                    loaded_reg[gi]  <= 1'b0;
                end else if (hit_missing) begin
                    present_reg[gi] <= 1'b0;
                    settle_reg[gi]  <= '0;
                    loaded_reg[gi]  <= 1'b0;
                end else begin
                    if (hit_sample) begin
                        present_reg[gi] <= 1'b1;
                    end
                    if (sec_tick && present_reg[gi]
                        && settle_reg[gi] != dle_pkg::SETTLE_COUNT) begin
                        settle_reg[gi] <= settle_reg[gi] + 6'h1;
                    end
                    if (do_load) begin
                        loaded_reg[gi] <= 1'b1;
                    end
                end
            end

            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    baseline_reg[gi] <= '0;
                    avg_reg[gi]      <= '0;
                end else if (do_load) begin
                    baseline_reg[gi] <= analog_pulse_width_value;
                    avg_reg[gi]      <= {analog_pulse_width_value, 4'h0};
                end else begin
                    if (hit_sample && loaded_reg[gi]) begin
                        avg_reg[gi] <= avg_next;
                    end
                    if (day_tick && loaded_reg[gi] && smoke) begin
                        baseline_reg[gi] <= avg_reg[gi][dle_pkg::AVG_W-1:dle_pkg::AVG_SHIFT];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < dle_pkg::LVL_COUNT; i++) begin
                level_reg[i] <= dle_pkg::LEVEL_RESET;
            end
        end else if (lvl_valid) begin
            level_reg[lvl_index] <= lvl_value;
        end
    end

    // ****************************************
    // Evaluation of the addressed detector
    // ****************************************
    dle_pkg::dle_det_type_t            rd_type;
    logic [W-1:0]                      rd_alarm;
    logic [W-1:0]                      rd_base;
    logic [dle_pkg::IDX_W-1:0]         rd_idx;
    logic signed [dle_pkg::SENS_W-1:0] rd_sens;
    logic                              is_variable;
    logic                              is_compensated;
    logic                              is_heat;
    logic                              is_drift_tracked;
    logic [W-1:0]                      gap;
    logic [19:0]                       gap_scaled;
    logic [W-1:0]                      pre_var;
    logic [W-1:0]                      pre_fixed;
    logic                              pre_exists;
    logic [W-1:0]                      pre_thr;
    logic [W-1:0]                      maint_sens;
    logic [W-1:0]                      maint_level;
    logic [W-1:0]                      normal_low;
    logic [W-1:0]                      low_limit;
    logic [W-1:0]                      win_lo;
    logic [W-1:0]                      win_hi;
    logic                              alarm_now;
    logic                              pre_now;
    logic                              maint_drift;
    logic                              maint_jump;
    logic                              maint_now;
    logic                              low_now;
    logic [W-1:0]                      value;

    assign value            = analog_pulse_width_value;
    assign rd_type          = type_reg[sample_addr];
    assign rd_alarm         = alarm_thr_reg[sample_addr];
    assign rd_base          = baseline_reg[sample_addr];
    assign rd_idx           = idx_reg[sample_addr];
    assign rd_sens          = sens_reg[sample_addr];
    assign is_heat          = (rd_type == dle_pkg::DET_HEAT);
    assign is_compensated   = (rd_type == dle_pkg::DET_PTIR) || (rd_type == dle_pkg::DET_HPHO);
    assign is_variable      = !is_compensated;
    assign is_drift_tracked = (rd_type == dle_pkg::DET_PHOTO) || (rd_type == dle_pkg::DET_ION)
                              || (rd_type == dle_pkg::DET_BEAM);

    assign alarm_now   = (value >= rd_alarm);

    // Gap held at zero if the baseline has climbed past the alarm level
    assign gap         = (rd_alarm > rd_base) ? rd_alarm - rd_base : '0;
    assign gap_scaled  = 20'({8'h0, gap} * 20'(dle_pkg::PRE_PERCENT)) / 20'(dle_pkg::PERCENT_BASE);
    assign pre_var     = rd_base + gap_scaled[W-1:0];
    assign pre_fixed   = level_reg[rd_idx - 4'h1];
    assign pre_exists  = is_variable || (rd_idx > 4'h1);
    assign pre_thr     = is_variable ? pre_var : pre_fixed;
    assign pre_now     = pre_exists && (value > pre_thr) && !alarm_now;

    // Larger sensitivity means a lower maintenance level; unlisted settings scale AL
    assign maint_sens  = (rd_sens == 4'sh1)  ? dle_pkg::MAINT_SENS_P1 :
                         (rd_sens == 4'sh0)  ? dle_pkg::MAINT_SENS_0  :
                         (rd_sens == -4'sh1) ? dle_pkg::MAINT_SENS_M1 :
                         (rd_sens == -4'sh2) ? dle_pkg::MAINT_SENS_M2 :
                         rd_alarm - (rd_alarm >> 2) - (rd_alarm >> 3);
    assign maint_level = maint_sens;
    assign maint_drift = is_drift_tracked && (rd_base >= maint_level);
    assign win_lo      = (rd_type == dle_pkg::DET_PTIR) ? dle_pkg::PTIR_MAINT_LO
                                                        : dle_pkg::HPHO_MAINT_LO;
    assign win_hi      = (rd_type == dle_pkg::DET_PTIR) ? dle_pkg::PTIR_MAINT_HI
                                                        : dle_pkg::HPHO_MAINT_HI;
    assign maint_jump  = is_compensated && (value >= win_lo) && (value <= win_hi);
    assign maint_now   = !is_heat && (maint_drift || maint_jump);

    assign normal_low  = (rd_type == dle_pkg::DET_HEAT) ? dle_pkg::HEAT_NORMAL_LOW :
                         (rd_type == dle_pkg::DET_PTIR) ? dle_pkg::PTIR_NORMAL_LOW :
                         (rd_type == dle_pkg::DET_HPHO) ? dle_pkg::HPHO_NORMAL_LOW :
                         dle_pkg::PHOTO_NORMAL_LOW;
    assign low_limit   = W'((20'({8'h0, normal_low}) * 20'(dle_pkg::LOW_PERCENT))
                            / 20'(dle_pkg::PERCENT_BASE));
    assign low_now     = (value < low_limit);

    // ****************************************
    // Result register
    // ****************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            result_valid              <= 1'b0;
            result_addr               <= '0;
            result_value              <= '0;
            result_clean_air_baseline <= '0;
            result_alarm              <= 1'b0;
            result_prealarm           <= 1'b0;
            result_maint              <= 1'b0;
            result_low                <= 1'b0;
        end else begin
            result_valid <= sample_valid;
            if (sample_valid) begin
                result_addr               <= sample_addr;
                result_value              <= value;
                result_clean_air_baseline <= rd_base;
                result_alarm              <= alarm_now;
                result_prealarm           <= pre_now;
                result_maint              <= maint_now;
                result_low                <= low_now;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_sample_heat;
        sample_valid && is_heat;
    endsequence

    sequence s_fixed_level1;
        sample_valid && is_compensated && rd_idx == 4'h1;
    endsequence

    AST_ALARM_AT_THRESHOLD: assert property (@(posedge clock) disable iff (!reset_n)
        sample_valid |=> (result_alarm == ($past(value) >= $past(rd_alarm))))
        else $error("alarm state does not follow threshold");
    AST_CFG_THRESHOLD: assert property (@(posedge clock) disable iff (!reset_n)
        cfg_valid |=> (alarm_thr_reg[$past(cfg_addr)] == $past(cfg_alarm_threshold_level)))
        else $error("alarm threshold not stored");
    AST_PREALARM_GAP: assert property (@(posedge clock) disable iff (!reset_n)
        (sample_valid && is_variable && !alarm_now && value > pre_var && rd_alarm > rd_base)
        |=> result_prealarm)
        else $error("pre-alarm missed above baseline gap");
    AST_LEVEL1_NO_PREALARM: assert property (@(posedge clock) disable iff (!reset_n)
        s_fixed_level1 |=> !result_prealarm)
        else $error("pre-alarm raised at level one");
    AST_HEAT_NO_MAINT: assert property (@(posedge clock) disable iff (!reset_n)
        s_sample_heat |=> !result_maint)
        else $error("maintenance raised for heat detector");
    AST_MAINT_1328: assert property (@(posedge clock) disable iff (!reset_n)
        (sample_valid && rd_type == dle_pkg::DET_PHOTO && rd_sens == 4'sh0
         && rd_base >= 12'h530) |=> result_maint)
        else $error("maintenance level wrong at sensitivity zero");
    AST_JUMP_MAINT: assert property (@(posedge clock) disable iff (!reset_n)
        (sample_valid && rd_type == dle_pkg::DET_PTIR && value >= 12'h0F0 && value <= 12'h160)
        |=> result_maint)
        else $error("maintenance jump not recognised");
    AST_BASELINE_STEADY: assert property (@(posedge clock) disable iff (!reset_n)
        !$stable(baseline_reg[0]) |-> ($past(day_tick) || $past(g_det[0].do_load)))
        else $error("baseline moved outside a day update or load");
    AST_SETTLE_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(loaded_reg[0]) |-> $past(settle_reg[0]) == 6'h3C)
        else $error("baseline loaded before sixty seconds");
    AST_RESULT_PULSE: assert property (@(posedge clock) disable iff (!reset_n)
        (sample_valid ##1 !sample_valid) |-> (result_valid ##1 !result_valid))
        else $error("result strobe not one cycle per sample");

endmodule

/* dle_detector_model.sv */
// Detector model: turns bench requests into sample strobes on the loop side.
// Assumes requests change just after the rising clock edge.
`timescale 1ns/1ns
module dle_detector_model (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        req,
    input  wire logic [3:0]  req_addr,
    input  wire logic [11:0] req_value,
    output logic             sample_valid,
    output logic [3:0]       sample_addr,
    output logic [11:0]      analog_pulse_width_value
);
    // ****************************************
    // Detector replies
    // ****************************************
    // Idle line inverts on every idle cycle, so a stale reading cannot pass
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sample_valid             <= 1'b0;
            sample_addr              <= 4'h0;
            analog_pulse_width_value <= 12'h000;
        end else if (req) begin
            sample_valid             <= 1'b1;
            sample_addr              <= req_addr;
            analog_pulse_width_value <= req_value;
        end else begin
            sample_valid             <= 1'b0;
            analog_pulse_width_value <= ~analog_pulse_width_value;
        end
    end
endmodule

/* testbench.sv */
// Self-checking bench for the detector level evaluator.
// Assumes short seconds (10 cycles) and a day too long to elapse here.
`timescale 1ns/1ns
module testbench;
    logic        clock, reset_n = 1'b0, req = 1'b0, missing_valid = 1'b0;
    logic        cfg_valid = 1'b0, lvl_valid = 1'b0;
    logic [3:0]  req_addr = 4'h0, missing_addr = 4'h0, cfg_addr = 4'h0;
    logic [3:0]  cfg_level_index = 4'h0, lvl_index = 4'h0;
    logic [11:0] req_value = 12'h000, cfg_alarm_threshold_level = 12'h000;
    logic [11:0] lvl_value = 12'h000;
    logic signed [3:0] cfg_sensitivity = 4'h0;
    dle_pkg::dle_det_type_t cfg_type = dle_pkg::DET_PHOTO;
    logic        sample_valid, result_valid, r_al, r_pre, r_mt, r_lo;
    logic [3:0]  sample_addr, result_addr;
    logic [11:0] apw, result_value, result_base;
    logic [32:0] q[$];
    logic [32:0] e;
    logic [31:0] rnd;
    int miscompares, samples_checked, cyc, ty[16], se[16], bl[16], ts[16], ld[16], ms[16];
    int al[16] = '{default: 4095};
    int ix[16] = '{default: 1};
    int lt[16] = '{default: 4095};
    int lo_t[6] = '{52, 52, 52, 83, 76, 86};
    logic [15:0] bt[22] = '{16'h07CF, 16'h07D0, 16'h053C, 16'h053D, 16'h0033, 16'h0034,
        16'h3500, 16'h3501, 16'h30F0, 16'h3160, 16'h3161, 16'h304B, 16'h304C, 16'h3670,
        16'h40EF, 16'h42B0, 16'h42B1, 16'h4055, 16'h4056, 16'h4730, 16'h2052, 16'h2053};
    wire logic [31:0] got = {result_addr, result_value, result_base, r_al, r_pre, r_mt, r_lo};

    // ****************************************
    // Instances
    // ****************************************
    dle_detector_model partner (.clock(clock), .reset_n(reset_n), .req(req),
        .req_addr(req_addr), .req_value(req_value), .sample_valid(sample_valid),
        .sample_addr(sample_addr), .analog_pulse_width_value(apw));
    dle_evaluator #(.CYCLES_PER_SEC(10), .SECONDS_PER_DAY(100000)) DUT (
        .clock(clock), .reset_n(reset_n), .sample_valid(sample_valid),
        .sample_addr(sample_addr), .analog_pulse_width_value(apw),
        .missing_valid(missing_valid), .missing_addr(missing_addr),
        .cfg_valid(cfg_valid), .cfg_addr(cfg_addr), .cfg_type(cfg_type),
        .cfg_alarm_threshold_level(cfg_alarm_threshold_level),
        .cfg_level_index(cfg_level_index), .cfg_sensitivity(cfg_sensitivity),
        .lvl_valid(lvl_valid), .lvl_index(lvl_index), .lvl_value(lvl_value),
        .result_valid(result_valid), .result_addr(result_addr),
        .result_value(result_value), .result_clean_air_baseline(result_base),
        .result_alarm(r_al), .result_prealarm(r_pre), .result_maint(r_mt), .result_low(r_lo));

    // ****************************************
    // Reference and tasks
    // ****************************************
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [3:0] ref_f(int a, int v);
        int p;
        int m;
        logic x;
        logic mt;
        x = v >= al[a];
        if (ty[a] >= 4) p = (ix[a] <= 1) ? 9999 : lt[ix[a] - 1];
        else p = bl[a] + ((al[a] > bl[a]) ? 67 * (al[a] - bl[a]) / 100 : 0);
        case (se[a])
            1: m = 1168;
            0: m = 1328;
            -1: m = 1424;
            -2: m = 1568;
            default: m = al[a] - al[a] / 4 - al[a] / 8;
        endcase
        if (ty[a] == 3) mt = 1'b0;
        else if (ty[a] == 4) mt = v >= 240 && v <= 352;
        else if (ty[a] == 5) mt = v >= 240 && v <= 688;
        else mt = bl[a] >= m;
        return {x, v > p && !x, mt, v < lo_t[ty[a]]};
    endfunction

    task automatic smp(int a, int v);
        logic c;
        c = ms[a] == 0;
        if (ms[a] == 1) ts[a] = cyc;
        if (ms[a] == 1) ms[a] = 2;
        @(posedge clock);
        req       <= 1'b1;
        req_addr  <= a[3:0];
        req_value <= v[11:0];
        q.push_back({c, a[3:0], v[11:0], bl[a][11:0], ref_f(a, v)});
        if (ld[a] == 0 && cyc - ts[a] > 700) begin
            bl[a] = v;
            ld[a] = 1;
            ms[a] = 0;
        end
    endtask

    task automatic idle();
        @(posedge clock);
        req <= 1'b0;
    endtask

    task automatic cfg(int a, int t, int th, int i, int s);
        @(posedge clock);
        cfg_valid                 <= 1'b1;
        cfg_addr                  <= a[3:0];
        cfg_type                  <= dle_pkg::dle_det_type_t'(t[2:0]);
        cfg_alarm_threshold_level <= th[11:0];
        cfg_level_index           <= i[3:0];
        cfg_sensitivity           <= s[3:0];
        ty[a] = t;
        al[a] = th;
        ix[a] = i;
        se[a] = s;
        @(posedge clock);
        cfg_valid <= 1'b0;
    endtask

    task automatic cmp(logic [31:0] g, logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic results();
        $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ****************************************
    // Processes
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        #300000;
        miscompares++;
        results();
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (result_valid === 1'b1 && q.size() == 0) cmp(got, 32'hFFFFFFFF);
        else if (result_valid === 1'b1) begin
            e = q.pop_front();
            if (e[32]) cmp(got, e[31:0]);
        end
    end

    initial begin
        rnd = 32'h6FD07579;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        cfg(0, 0, 2000, 1, 0);
        cfg(1, 0, 2192, 1, -1);
        cfg(2, 3, 2000, 1, 0);
        cfg(3, 4, 1648, 8, 0);
        cfg(4, 5, 1840, 1, 0);
        cfg(5, 1, 2496, 1, -2);
        cfg(6, 2, 1600, 1, 1);
        cfg(7, 0, 2000, 1, -3);
        cfg(8, 0, 1600, 1, 1);
        lvl_valid <= 1'b1;
        lvl_index <= 4'h7;
        lvl_value <= 12'h500;
        lt[7] = 1280;
        @(posedge clock);
        lvl_valid <= 1'b0;
        foreach (bt[k]) smp(int'(bt[k][15:12]), int'(bt[k][11:0]));
        repeat (40) begin
            rnd = lfsr(rnd);
            smp(int'(rnd[2:0]), int'(rnd[15:4]));
        end
        idle();
        // Baselines load only past 60 s of power
        repeat (720) @(posedge clock);
        for (int a = 0; a < 16; a++) smp(a, 1400);
        repeat (40) begin
            rnd = lfsr(rnd);
            smp(int'(rnd[3:0]), int'(rnd[15:4]));
        end
        idle();
        missing_valid <= 1'b1;
        missing_addr  <= 4'h0;
        ld[0] = 0;
        ms[0] = 1;
        @(posedge clock);
        missing_valid <= 1'b0;
        smp(0, 900);
        idle();
        repeat (720) @(posedge clock);
        smp(0, 800);
        smp(0, 1330);
        idle();
        for (int w = 0; w < 20 && q.size() > 0; w++) @(posedge clock);
        if (q.size() != 0) miscompares++;
        results();
    end
endmodule
